// file: pkg/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
   // ------------------------------------------------------------
   // Serial word layout.
   // ------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 10;
   localparam int NUM_CHANNELS = 4;
   localparam int CHAN_HI = 15;
   localparam int CHAN_LO = 14;
   localparam int PWR_BIT = 13;
   localparam int SPD_BIT = 12;
   localparam int CODE_HI = 11;
   localparam int CODE_LO = 2;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_FULL = 5'h10;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 5'h00;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 5'h01;
   // ------------------------------------------------------------
   // Reset values and buffering.
   // ------------------------------------------------------------
   localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   localparam int FIFO_DEPTH = 8;
   // Receive state machine, one-hot.
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_SHIFT = 3'b010,
      RX_DONE = 3'b100
   } rx_state_t;
endpackage

// file: pkg/word_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries received 16-bit words between the receiver, FIFO and latches.
interface word_stream_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hw/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Streams in and out.
   word_stream_if.sink wr,
   word_stream_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH]; // Word storage.
   logic [AW-1:0] wr_ptr; // Next slot to fill.
   logic [AW-1:0] rd_ptr; // Oldest word.
   logic [AW:0] count; // Words held.
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;
   // ------------------------------------------------------------
   // Handshakes: full and empty come straight from the count.
   // ------------------------------------------------------------
   assign wr.ready = (count != DEPTH_CNT);
   assign rd.valid = (count != '0);
   assign rd.data = mem[rd_ptr];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;
   // Next pointer and count values.
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
      end
      if (push && !pop) begin
         next_count = count + CNT_ONE;
      end else if (pop && !push) begin
         next_count = count - CNT_ONE;
      end
   end
   // Register pointers; storage is written without reset.
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= wr.data;
      end
   end
endmodule
`default_nettype wire

// file: hw/serial_word_rx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_word_rx
   import dac_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Synchronised link pins.
   input wire logic sclk_fall, // One-cycle pulse on a serial clock falling edge.
   input wire logic frame_sync, // Synchronised frame sync level.
   input wire logic frame_fall, // Pulse on a frame sync falling edge.
   input wire logic chip_select_n, // Synchronised chip select.
   input wire logic serial_data, // Synchronised data.
   // Received words.
   word_stream_if.source words,
   output logic overrun // Pulse: a word was dropped for lack of room.
);
   rx_state_t state;
   rx_state_t next_state;
   logic [WORD_BITS-1:0] shifter; // Bits arrive MSB first.
   logic [WORD_BITS-1:0] next_shifter;
   logic [BIT_CNT_W-1:0] bit_cnt; // Bits taken this frame.
   logic [BIT_CNT_W-1:0] next_bit_cnt;
   logic [WORD_BITS-1:0] word;
   logic [WORD_BITS-1:0] next_word;
   logic word_valid;
   logic next_word_valid;
   logic next_overrun;
   assign words.valid = word_valid;
   assign words.data = word;
   // ------------------------------------------------------------
   // Frame receiver.
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_shifter = shifter;
      next_bit_cnt = bit_cnt;
      next_word = word;
      next_word_valid = word_valid && !words.ready;
      next_overrun = 1'b0;
      unique case (state)
         RX_IDLE: begin
            // A frame starts only while selected.
            if (frame_fall && !chip_select_n) begin
               next_state = RX_SHIFT;
               next_bit_cnt = BIT_CNT_ZERO;
            end
         end
         RX_SHIFT: begin
            if (chip_select_n) begin
               // Deselect abandons the frame.
               next_state = RX_IDLE;
            end else if (frame_sync && bit_cnt != BIT_CNT_ZERO) begin
               // Early rise of frame sync ends the word short.
               next_state = RX_DONE;
            end else if (sclk_fall) begin
               next_shifter = {shifter[WORD_BITS-2:0], serial_data};
               next_bit_cnt = bit_cnt + BIT_CNT_ONE;
               if (bit_cnt + BIT_CNT_ONE == BIT_CNT_FULL) begin
                  next_state = RX_DONE;
               end
            end
         end
         RX_DONE: begin
            // A short word is left-aligned so field positions still hold.
            next_word = shifter << (BIT_CNT_FULL - bit_cnt);
            next_state = RX_IDLE;
            if (word_valid && !words.ready) begin
               next_overrun = 1'b1;
            end else begin
               next_word_valid = 1'b1;
            end
         end
         default: next_state = RX_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= RX_IDLE;
         shifter <= WORD_RESET;
         bit_cnt <= BIT_CNT_ZERO;
         word <= WORD_RESET;
         word_valid <= 1'b0;
         overrun <= 1'b0;
      end else begin
         state <= next_state;
         shifter <= next_shifter;
         bit_cnt <= next_bit_cnt;
         word <= next_word;
         word_valid <= next_word_valid;
         overrun <= next_overrun;
      end
   end
endmodule
`default_nettype wire

// file: hw/quad_dac_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_control
   import dac_ctrl_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Serial link pins, asynchronous to clk.
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic frame_sync,
   input wire logic chip_select_n,
   // Control pins, asynchronous to clk.
   input wire logic output_load_n,
   input wire logic hw_power_down_n,
   // Channel A controls.
   output logic [CODE_BITS-1:0] channel_a_output,
   output logic channel_a_power_down,
   output logic channel_a_fast,
   // Channel B controls.
   output logic [CODE_BITS-1:0] channel_b_output,
   output logic channel_b_power_down,
   output logic channel_b_fast,
   // Channel C controls.
   output logic [CODE_BITS-1:0] channel_c_output,
   output logic channel_c_power_down,
   output logic channel_c_fast,
   // Channel D controls.
   output logic [CODE_BITS-1:0] channel_d_output,
   output logic channel_d_power_down,
   output logic channel_d_fast,
   // Status.
   output logic word_overrun
);
   // ------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------
   localparam int NPINS = 6;
   localparam int P_SCLK = 0;
   localparam int P_DIN = 1;
   localparam int P_FS = 2;
   localparam int P_CS = 3;
   localparam int P_LOAD = 4;
   localparam int P_PD = 5;
   logic [NPINS-1:0] pins; // Raw pin levels.
   logic [NPINS-1:0] sync1; // First stage, read only by sync2.
   logic [NPINS-1:0] sync2; // Safe levels.
   logic [NPINS-1:0] sync_prev; // Previous safe levels, for edges.
   // Reset levels match each pin's idle level: the link clock, frame sync,
   // chip select, load and power-down idle high and data idles low. A
   // mismatch here would show a false edge right after reset.
   localparam logic [NPINS-1:0] SYNC_IDLE = 6'h3D;
   logic sclk_fall;
   logic frame_fall;
   assign pins = {hw_power_down_n, output_load_n, chip_select_n,
                  frame_sync, serial_data, serial_clock};
   // Two synchroniser flops and an edge flop per pin; every pin starts at its idle level.
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1 <= SYNC_IDLE;
         sync2 <= SYNC_IDLE;
         sync_prev <= SYNC_IDLE;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync_prev <= sync2;
      end
   end
   // Edges come from the second stage and its delayed copy, which keeps
   // clock and data aligned: the bit is sampled at the same delay.
   assign sclk_fall = sync_prev[P_SCLK] && !sync2[P_SCLK];
   assign frame_fall = sync_prev[P_FS] && !sync2[P_FS];
   // ------------------------------------------------------------
   // Receiver and FIFO.
   // ------------------------------------------------------------
   word_stream_if #(.WIDTH(WORD_BITS)) rx_words ();
   word_stream_if #(.WIDTH(WORD_BITS)) held_words ();
   serial_word_rx u_rx (
      .clk(clk),
      .srst(srst),
      .sclk_fall(sclk_fall),
      .frame_sync(sync2[P_FS]),
      .frame_fall(frame_fall),
      .chip_select_n(sync2[P_CS]),
      .serial_data(sync_prev[P_DIN]),
      .words(rx_words),
      .overrun(word_overrun)
   );
   word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_WORDS)) u_fifo (
      .clk(clk),
      .srst(srst),
      .wr(rx_words),
      .rd(held_words)
   );
   // ------------------------------------------------------------
   // Input latches: each word lands in its channel at once.
   // ------------------------------------------------------------
   // Field decode, used for every popped word.
   function automatic logic [1:0] word_channel(input logic [WORD_BITS-1:0] w);
      return w[CHAN_HI:CHAN_LO];
   endfunction
   logic [CODE_BITS-1:0] in_code [NUM_CHANNELS]; // Received codes.
   logic [CODE_BITS-1:0] next_in_code [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] in_pwr; // Received power bits.
   logic [NUM_CHANNELS-1:0] next_in_pwr;
   logic [NUM_CHANNELS-1:0] in_spd; // Received speed bits.
   logic [NUM_CHANNELS-1:0] next_in_spd;
   logic [NUM_CHANNELS-1:0] pending; // Latch holds a word not yet applied.
   logic [NUM_CHANNELS-1:0] next_pending;
   // Output stage.
   logic [CODE_BITS-1:0] out_code [NUM_CHANNELS];
   logic [CODE_BITS-1:0] next_out_code [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] out_pwr;
   logic [NUM_CHANNELS-1:0] next_out_pwr;
   logic [NUM_CHANNELS-1:0] out_spd;
   logic [NUM_CHANNELS-1:0] next_out_spd;
   logic load_open;
   // Words drain continuously, so the FIFO never holds more than one word.
   assign held_words.ready = 1'b1;
   assign load_open = !sync2[P_LOAD];
   // Next values of input latches and the output stage.
   always_comb begin
      next_in_code = in_code;
      next_in_pwr = in_pwr;
      next_in_spd = in_spd;
      next_pending = pending;
      next_out_code = out_code;
      next_out_pwr = out_pwr;
      next_out_spd = out_spd;
      if (held_words.valid) begin
         // Only the addressed channel changes.
         next_in_code[word_channel(held_words.data)] =
            held_words.data[CODE_HI:CODE_LO];
         next_in_pwr[word_channel(held_words.data)] = held_words.data[PWR_BIT];
         next_in_spd[word_channel(held_words.data)] = held_words.data[SPD_BIT];
         next_pending[word_channel(held_words.data)] = 1'b1;
      end
      // While load is low, pending latches flow to the outputs; a high
      // load freezes them all so several channels move together.
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (load_open && pending[i]) begin
            next_out_code[i] = in_code[i];
            next_out_pwr[i] = in_pwr[i];
            next_out_spd[i] = in_spd[i];
            next_pending[i] = 1'b0;
         end
      end
      // A word arriving while an older one is applied keeps pending set.
      if (held_words.valid) begin
         next_pending[word_channel(held_words.data)] = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            in_code[i] <= CODE_RESET;
            out_code[i] <= CODE_RESET;
         end
         in_pwr <= '0;
         in_spd <= '0;
         pending <= '0;
         out_pwr <= '0;
         out_spd <= '0;
      end else begin
         in_code <= next_in_code;
         in_pwr <= next_in_pwr;
         in_spd <= next_in_spd;
         pending <= next_pending;
         out_code <= next_out_code;
         out_pwr <= next_out_pwr;
         out_spd <= next_out_spd;
      end
   end
   // ------------------------------------------------------------
   // Outputs. The hardware power-down overrides every channel.
   // ------------------------------------------------------------
   logic [NUM_CHANNELS-1:0] pd_eff;
   assign pd_eff = out_pwr | {NUM_CHANNELS{!sync2[P_PD]}};
   assign channel_a_output = out_code[0];
   assign channel_b_output = out_code[1];
   assign channel_c_output = out_code[2];
   assign channel_d_output = out_code[3];
   assign channel_a_power_down = pd_eff[0];
   assign channel_b_power_down = pd_eff[1];
   assign channel_c_power_down = pd_eff[2];
   assign channel_d_power_down = pd_eff[3];
   assign channel_a_fast = out_spd[0];
   assign channel_b_fast = out_spd[1];
   assign channel_c_fast = out_spd[2];
   assign channel_d_fast = out_spd[3];
endmodule
`default_nettype wire

// file: test/quad_dac_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// Port checker for the DAC control.
// ---------------------------------
module quad_dac_sva
   import dac_ctrl_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Pins.
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic frame_sync,
   input wire logic chip_select_n,
   input wire logic output_load_n,
   input wire logic hw_power_down_n,
   // Channels and status.
   input wire logic [CODE_BITS-1:0] channel_a_output,
   input wire logic channel_a_power_down,
   input wire logic channel_a_fast,
   input wire logic [CODE_BITS-1:0] channel_b_output,
   input wire logic channel_b_power_down,
   input wire logic channel_b_fast,
   input wire logic [CODE_BITS-1:0] channel_c_output,
   input wire logic channel_c_power_down,
   input wire logic channel_c_fast,
   input wire logic [CODE_BITS-1:0] channel_d_output,
   input wire logic channel_d_power_down,
   input wire logic channel_d_fast,
   input wire logic word_overrun
);
   // Quiet counts cycles since a pin edge that may move a code; idle counts
   // cycles of chip select high with load open. Both saturate, never wrap.
   logic [4:0] quiet, next_quiet, idle, next_idle;
   logic [2:0] prev, next_prev; // Clock, frame sync and load one cycle ago.
   wire logic [4*CODE_BITS-1:0] codes = {channel_a_output, channel_b_output,
      channel_c_output, channel_d_output};
   wire logic [3:0] pds = {channel_a_power_down, channel_b_power_down,
      channel_c_power_down, channel_d_power_down};
   wire logic [3:0] fasts = {channel_a_fast, channel_b_fast, channel_c_fast, channel_d_fast};
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Next values of the helper counters.
   always_comb begin
      next_prev = {serial_clock, frame_sync, output_load_n};
      next_quiet = quiet + {4'h0, quiet != 5'h1f};
      next_idle = idle + {4'h0, idle != 5'h1f};
      if ((prev[2] && !serial_clock) || (!prev[1] && frame_sync) || (prev[0] && !output_load_n)) begin
         next_quiet = 5'h00; // A clock fall, frame end or load opening.
      end
      if (!chip_select_n || output_load_n) begin
         next_idle = 5'h00; // Selected, or outputs held.
      end
   end
   // Registers of the helper counters.
   always_ff @(posedge clk) begin
      if (srst) begin
         quiet <= 5'h00;
         idle <= 5'h00;
         prev <= 3'h7;
      end else begin
         quiet <= next_quiet;
         idle <= next_idle;
         prev <= next_prev;
      end
   end
   property p_pd_pin; (!hw_power_down_n) [*5] |-> (&pds); endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("pin power-down not applied");
   property p_pd_fall; $fell(hw_power_down_n) |-> ##[1:5] (&pds); endproperty
   a_pd_fall: assert property (p_pd_fall) else $error("power-down pin too slow");
   property p_hold_code; output_load_n [*6] |-> $stable(codes); endproperty
   a_hold_code: assert property (p_hold_code) else $error("code moved with load held");
   property p_hold_fast; output_load_n [*6] |-> $stable(fasts); endproperty
   a_hold_fast: assert property (p_hold_fast) else $error("speed moved with load held");
   property p_hold_pd; (hw_power_down_n && output_load_n) [*6] |-> $stable(pds); endproperty
   a_hold_pd: assert property (p_hold_pd) else $error("power bit moved with load held");
   property p_unselected; idle > 5'h13 |-> $stable({codes, fasts}); endproperty
   a_unselected: assert property (p_unselected) else $error("output moved while unselected");
   property p_quiet; quiet > 5'h0f |-> $stable(codes); endproperty
   a_quiet: assert property (p_quiet) else $error("code moved with no link edge");
   property p_no_drop; !word_overrun; endproperty
   a_no_drop: assert property (p_no_drop) else $error("word dropped");
   c_word_d: cover property ($changed(channel_d_output));
   c_idle: cover property (idle == 5'h14);
   c_pd: cover property ($fell(hw_power_down_n));
endmodule
bind quad_dac_serial_control quad_dac_sva #(.FIFO_WORDS(FIFO_WORDS)) u_sva (.*);
`default_nettype wire

// file: test/host_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// Host serial port that feeds the DAC.
// ------------------------------------
module host_serial_port (
   // Clock that paces the host.
   input wire logic clk,
   // Link pins.
   output logic serial_clock,
   output logic serial_data,
   output logic frame_sync,
   output logic chip_select_n
);
   // The link clock stands high between frames.
   initial begin
      serial_clock = 1'b1;
      serial_data = 1'b0;
      frame_sync = 1'b1;
      chip_select_n = 1'b1;
   end
   // Half a link period: 16 cycles of 5 ns.
   task automatic half;
      repeat (16) @(posedge clk);
   endtask
   // Sends the top nbits of word, MSB first; sel low keeps chip select high.
   task automatic send(input logic [15:0] word, input logic [4:0] nbits, input logic sel);
      chip_select_n <= !sel;
      half();
      frame_sync <= 1'b0;
      half();
      for (int i = 0; i < nbits; i++) begin
         serial_data <= word[15-i];
         half();
         serial_clock <= 1'b0;
         half();
         serial_clock <= 1'b1;
      end
      half();
      frame_sync <= 1'b1;
      serial_data <= !serial_data; // A released line shows no stale bit.
      half();
      chip_select_n <= 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// file: test/quad_dac_serial_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_control_tb_top
   import dac_ctrl_pkg::*;
;
   // ---------------------------
   // Word table and signals.
   // ---------------------------
   typedef struct packed {
      logic [WORD_BITS-1:0] word;
      logic [4:0] nbits; // Bits sent before frame sync rises.
      logic [1:0] ch;
      logic [CODE_BITS-1:0] code;
      logic pd;
      logic fast;
   } row_t;
   localparam row_t ROWS [12] = '{
      '{16'h0fff, 5'h10, 2'h0, 10'h3ff, 1'b0, 1'b0},
      '{16'h5000, 5'h10, 2'h1, 10'h000, 1'b0, 1'b1},
      '{16'ha804, 5'h10, 2'h2, 10'h201, 1'b1, 1'b0},
      '{16'hf557, 5'h10, 2'h3, 10'h155, 1'b1, 1'b1},
      '{16'h3aaa, 5'h10, 2'h0, 10'h2aa, 1'b1, 1'b1},
      '{16'h4000, 5'h10, 2'h1, 10'h000, 1'b0, 1'b0},
      '{16'h8000, 5'h10, 2'h2, 10'h000, 1'b0, 1'b0},
      // Held load: channel A twice, so the later word must win.
      '{16'h0404, 5'h10, 2'h0, 10'h101, 1'b0, 1'b0},
      '{16'hc3fc, 5'h10, 2'h3, 10'h0ff, 1'b0, 1'b0},
      '{16'h2ffc, 5'h10, 2'h0, 10'h3ff, 1'b1, 1'b0},
      // Unselected frame, then a ten-bit short word.
      '{16'h7ffc, 5'h10, 2'h1, 10'h3ff, 1'b1, 1'b1},
      '{16'hb3ff, 5'h0a, 2'h2, 10'h0f0, 1'b1, 1'b1}
   };
   localparam int LIMIT = 20000; // The run needs about 7000 cycles.
   logic clk, srst, output_load_n, hw_power_down_n;
   wire logic serial_clock, serial_data, frame_sync, chip_select_n, word_overrun;
   wire logic [CODE_BITS-1:0] channel_a_output, channel_b_output;
   wire logic [CODE_BITS-1:0] channel_c_output, channel_d_output;
   wire logic channel_a_power_down, channel_b_power_down;
   wire logic channel_c_power_down, channel_d_power_down;
   wire logic channel_a_fast, channel_b_fast, channel_c_fast, channel_d_fast;
   logic [CODE_BITS-1:0] exp_code [4];
   logic exp_pd [4], exp_fast [4];
   int miscompares, comparisons;
   int cycles = 0;
   quad_dac_serial_control dut (.*);
   host_serial_port u_host (.*);
   // 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // A hung run counts as a mismatch.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end
   // ---------------------------
   // Checking tasks.
   // ---------------------------
   task automatic cmp(input logic [CODE_BITS-1:0] got, input logic [CODE_BITS-1:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, want);
      end
   endtask
   task automatic chk(input logic [CODE_BITS-1:0] c, input logic p, input logic f, input int i,
      input logic pin);
      cmp(c, exp_code[i]);
      cmp({9'h000, p}, {9'h000, exp_pd[i] | pin});
      cmp({9'h000, f}, {9'h000, exp_fast[i]});
   endtask
   task automatic check_all(input logic pin);
      chk(channel_a_output, channel_a_power_down, channel_a_fast, 0, pin);
      chk(channel_b_output, channel_b_power_down, channel_b_fast, 1, pin);
      chk(channel_c_output, channel_c_power_down, channel_c_fast, 2, pin);
      chk(channel_d_output, channel_d_power_down, channel_d_fast, 3, pin);
      cmp({9'h000, word_overrun}, 10'h000);
   endtask
   task automatic put(input int k, input logic sel);
      u_host.send(ROWS[k].word, ROWS[k].nbits, sel);
      repeat (4) @(posedge clk);
   endtask
   task automatic take(input int k);
      exp_code[ROWS[k].ch] = ROWS[k].code;
      exp_pd[ROWS[k].ch] = ROWS[k].pd;
      exp_fast[ROWS[k].ch] = ROWS[k].fast;
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ---------------------------
   // Main sequence.
   // ---------------------------
   initial begin
      srst = 1'b1;
      output_load_n = 1'b0;
      hw_power_down_n = 1'b1;
      miscompares = 0;
      comparisons = 0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         exp_code[i] = CODE_RESET;
         exp_pd[i] = 1'b0;
         exp_fast[i] = 1'b0;
      end
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      check_all(1'b0);
      // Ordinary words with load open.
      for (int k = 0; k < 7; k++) begin
         put(k, 1'b1);
         take(k);
         check_all(1'b0);
      end
      // Load held: nothing moves until it opens, then all move together.
      output_load_n <= 1'b1;
      for (int k = 7; k < 10; k++) begin
         put(k, 1'b1);
      end
      check_all(1'b0);
      output_load_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int k = 7; k < 10; k++) begin
         take(k);
      end
      check_all(1'b0);
      // Power-down pin overrides every channel, then lets go.
      hw_power_down_n <= 1'b0;
      repeat (6) @(posedge clk);
      check_all(1'b1);
      hw_power_down_n <= 1'b1;
      repeat (6) @(posedge clk);
      check_all(1'b0);
      // A frame with chip select high changes nothing.
      put(10, 1'b0);
      check_all(1'b0);
      // Frame sync rising after ten bits ends a short word.
      put(11, 1'b1);
      take(11);
      check_all(1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
